/* code_word_modulator.sv */
// Code word modulator: register port, segment sequencer and line coder.
// Operation
// - Modulation bit picks PWM or Manchester coding.
// - PWM element 400us at rate 00, 200us at 01.
// - PWM element 200us at rate 10, 100us at 11.
// - Manchester element 800us at 00, 400us at 01.
// - PWM bit cell is three elements.
// - PWM preamble 31, then header 10 elements.
// - PWM hopping portion lasts 96 elements.
// - PWM fixed portion 105 elements after hopping.
// - PWM guard 17 at rate 00, 33 at 01.
// - Manchester preamble 31, then header 4 elements.
// - Manchester start and stop bits, two elements each.
// - Manchester hopping portion lasts 64 elements.
// - Manchester fixed portion 70 elements, directly after.
// - Manchester guard 9 at rate 00, 17 at 01.
// - All durations counted from the clock.
// - Fixed: serial, buttons 3,0,1,2, low voltage, checksum.
// - Bits 0 to 66 between header and guard.
module code_word_modulator
	import code_word_pkg::*;
#(
	parameter int ELEMENT_BASE_CYCLES = BASE_ELEMENT_CYCLES
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic clockEnable,
	input wire logic [7:0] address,
	input wire logic [31:0] writeData,
	input wire logic writeStrobe,
	input wire logic readStrobe,
	output logic [31:0] readData,
	output logic dataOut,
	output logic busy,
	output logic wordDone
);

	// ----------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------
	logic [4:0] control;
	logic [31:0] hoppingCode;
	logic [27:0] serialNumber;
	logic [6:0] fixedStatus;
	logic [15:0] wordCount;
	logic [4:0] next_control;
	logic [31:0] next_hoppingCode;
	logic [27:0] next_serialNumber;
	logic [6:0] next_fixedStatus;
	logic [31:0] next_readData;

	always_comb
	begin
		next_control = control;
		next_hoppingCode = hoppingCode;
		next_serialNumber = serialNumber;
		next_fixedStatus = fixedStatus;
		next_readData = readData;
		if (writeStrobe)
		begin
			unique case (address)
				ADDR_CONTROL: next_control = writeData[4:0];
				ADDR_HOPPING: next_hoppingCode = writeData;
				ADDR_SERIAL: next_serialNumber = writeData[27:0];
				ADDR_FIXED: next_fixedStatus = writeData[6:0];
				default: next_control = control;
			endcase
		end
		if (readStrobe)
		begin
			unique case (address)
				ADDR_CONTROL: next_readData = {27'h0000000, control};
				ADDR_HOPPING: next_readData = hoppingCode;
				ADDR_SERIAL: next_readData = {4'h0, serialNumber};
				ADDR_FIXED: next_readData = {25'h0000000, fixedStatus};
				ADDR_STATUS: next_readData = {wordCount, 15'h0000, busy};
				default: next_readData = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			control <= CONTROL_RESET;
			hoppingCode <= HOPPING_RESET;
			serialNumber <= SERIAL_RESET;
			fixedStatus <= FIXED_RESET;
			readData <= 32'h00000000;
		end
		else if (clockEnable)
		begin
			control <= next_control;
			hoppingCode <= next_hoppingCode;
			serialNumber <= next_serialNumber;
			fixedStatus <= next_fixedStatus;
			readData <= next_readData;
		end
	end

	// ----------------------------------------------------------------
	// Segment sequencer
	// ----------------------------------------------------------------
	phase_e state;
	phase_e next_state;
	logic [31:0] tickCount;
	logic [31:0] next_tickCount;
	logic [31:0] elemCycles;
	logic [31:0] next_elemCycles;
	logic [6:0] elemCount;
	logic [6:0] next_elemCount;
	logic [6:0] bitIndex;
	logic [6:0] next_bitIndex;
	logic [66:0] dataWord;
	logic [66:0] next_dataWord;
	logic modLatched;
	logic next_modLatched;
	logic [1:0] rateLatched;
	logic [1:0] next_rateLatched;
	logic [15:0] next_wordCount;
	logic [31:0] segCycles;
	logic [31:0] next_segCycles;
	logic next_wordDone;
	logic [6:0] segLen;
	logic [6:0] guardLen;
	logic [3:0] startMult;
	logic elemEnd;
	logic segEnd;

	// Config is latched per word so a register write never bends a word in flight.
	always_comb
	begin
		unique case ({control[CTRL_MOD_BIT], control[CTRL_RATE_HIGH_BIT],
			control[CTRL_RATE_LOW_BIT]})
			3'h0: startMult = PWM_MULT_RATE00;
			3'h1: startMult = PWM_MULT_RATE01;
			3'h2: startMult = PWM_MULT_RATE10;
			3'h3: startMult = PWM_MULT_RATE11;
			3'h4: startMult = MAN_MULT_RATE00;
			default: startMult = MAN_MULT_RATE01;
		endcase
		unique case ({modLatched, rateLatched})
			3'h0: guardLen = GUARD_PWM_RATE00;
			3'h1: guardLen = GUARD_PWM_RATE01;
			3'h2: guardLen = GUARD_PWM_RATE10;
			3'h3: guardLen = GUARD_PWM_RATE11;
			3'h4: guardLen = GUARD_MAN_RATE00;
			default: guardLen = GUARD_MAN_RATE01;
		endcase
		unique case (state)
			PREAMBLE: segLen = PREAMBLE_ELEMS;
			HEADER: segLen = modLatched ? HEADER_MAN_ELEMS : HEADER_PWM_ELEMS;
			START_BIT: segLen = START_BIT_ELEMS;
			DATA: segLen = modLatched ? CELL_MAN_ELEMS : CELL_PWM_ELEMS;
			STOP_BIT: segLen = STOP_BIT_ELEMS;
			GUARD: segLen = guardLen;
			default: segLen = 7'h01;
		endcase
	end

	assign elemEnd = (tickCount == elemCycles - 32'd1);
	assign segEnd = (state != IDLE) && elemEnd && (elemCount == segLen - 7'd1);

	always_comb
	begin
		next_state = state;
		next_tickCount = tickCount;
		next_elemCount = elemCount;
		next_bitIndex = bitIndex;
		next_dataWord = dataWord;
		next_modLatched = modLatched;
		next_rateLatched = rateLatched;
		next_elemCycles = elemCycles;
		next_wordCount = wordCount;
		next_wordDone = 1'b0;
		next_segCycles = segEnd ? 32'd0 : segCycles + 32'd1;
		if (state == IDLE)
		begin
			next_segCycles = 32'd0;
			next_tickCount = 32'd0;
			next_elemCount = 7'd0;
			next_bitIndex = 7'd0;
			if (control[CTRL_ENABLE_BIT])
			begin
				next_state = PREAMBLE;
				next_modLatched = control[CTRL_MOD_BIT];
				next_rateLatched = {control[CTRL_RATE_HIGH_BIT], control[CTRL_RATE_LOW_BIT]};
				next_elemCycles = 32'(ELEMENT_BASE_CYCLES) * {28'h0000000, startMult};
				next_dataWord = {fixedStatus[FIX_CHECKSUM_HIGH_BIT], fixedStatus[FIX_CHECKSUM_LOW_BIT],
					fixedStatus[FIX_LOW_VOLTAGE_BIT], fixedStatus[2], fixedStatus[1],
					fixedStatus[0], fixedStatus[3], serialNumber, hoppingCode};
			end
		end
		else if (!elemEnd)
		begin
			next_tickCount = tickCount + 32'd1;
		end
		else
		begin
			next_tickCount = 32'd0;
			next_elemCount = elemCount + 7'd1;
			if (segEnd)
			begin
				next_elemCount = 7'd0;
				unique case (state)
					PREAMBLE: next_state = HEADER;
					HEADER: next_state = modLatched ? START_BIT : DATA;
					START_BIT: next_state = DATA;
					DATA:
					begin
						// Bit 0 goes first; the hopping part fills bits 0-31.
						next_dataWord = {1'b0, dataWord[66:1]};
						next_bitIndex = bitIndex + 7'd1;
						if (bitIndex == LAST_BIT_INDEX)
						begin
							next_state = modLatched ? STOP_BIT : GUARD;
						end
					end
					STOP_BIT: next_state = GUARD;
					GUARD:
					begin
						next_state = IDLE;
						next_wordDone = 1'b1;
						next_wordCount = wordCount + 16'd1;
					end
					default: next_state = IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state <= IDLE;
			tickCount <= 32'd0;
			elemCount <= 7'd0;
			bitIndex <= 7'd0;
			dataWord <= '0;
			modLatched <= 1'b0;
			rateLatched <= 2'h0;
			elemCycles <= 32'd1;
			wordCount <= 16'h0000;
			segCycles <= 32'd0;
			wordDone <= 1'b0;
		end
		else if (clockEnable)
		begin
			state <= next_state;
			tickCount <= next_tickCount;
			elemCount <= next_elemCount;
			bitIndex <= next_bitIndex;
			dataWord <= next_dataWord;
			modLatched <= next_modLatched;
			rateLatched <= next_rateLatched;
			elemCycles <= next_elemCycles;
			wordCount <= next_wordCount;
			segCycles <= next_segCycles;
			wordDone <= next_wordDone;
		end
	end

	// ----------------------------------------------------------------
	// Line coder
	// ----------------------------------------------------------------
	logic lineLevel;
	logic next_busy;

	// The pin lags the sequencer by one cycle, which keeps it glitch free.
	always_comb
	begin
		unique case (state)
			PREAMBLE: lineLevel = ~elemCount[0];
			START_BIT: lineLevel = elemCount[0];
			STOP_BIT: lineLevel = elemCount[0];
			DATA:
			begin
				if (modLatched)
				begin
					lineLevel = (elemCount == 7'd0) ? ~dataWord[0] : dataWord[0];
				end
				else
				begin
					lineLevel = (elemCount == 7'd0) || ((elemCount == 7'd1) && !dataWord[0]);
				end
			end
			default: lineLevel = 1'b0;
		endcase
		next_busy = (next_state != IDLE);
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			dataOut <= 1'b0;
			busy <= 1'b0;
		end
		else if (clockEnable)
		begin
			dataOut <= lineLevel;
			busy <= next_busy;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_mode_latch: assert property (@(posedge clk) disable iff (reset)
		(clockEnable && state == IDLE && control[CTRL_ENABLE_BIT])
		|=> (modLatched == $past(control[CTRL_MOD_BIT])))
		else $error("Modulation mode not taken at word start.");
	a_pwm_slow_rate: assert property (@(posedge clk) disable iff (reset)
		(clockEnable && segEnd && state == PREAMBLE && !modLatched && !rateLatched[1])
		|-> (segCycles == (rateLatched[0] ? 32'(62 * ELEMENT_BASE_CYCLES - 1)
			: 32'(124 * ELEMENT_BASE_CYCLES - 1))))
		else $error("PWM element wrong at rate 00 or 01.");
	a_pwm_fast_rate: assert property (@(posedge clk) disable iff (reset)
		(clockEnable && segEnd && state == PREAMBLE && !modLatched && rateLatched[1])
		|-> (segCycles == (rateLatched[0] ? 32'(31 * ELEMENT_BASE_CYCLES - 1)
			: 32'(62 * ELEMENT_BASE_CYCLES - 1))))
		else $error("PWM element wrong at rate 10 or 11.");
	a_man_rate: assert property (@(posedge clk) disable iff (reset)
		(clockEnable && segEnd && state == PREAMBLE && modLatched && !rateLatched[1])
		|-> (segCycles == (rateLatched[0] ? 32'(124 * ELEMENT_BASE_CYCLES - 1)
			: 32'(248 * ELEMENT_BASE_CYCLES - 1))))
		else $error("Manchester element wrong.");
	a_header_len: assert property (@(posedge clk) disable iff (reset)
		(clockEnable && segEnd && state == HEADER)
		|-> (segCycles == (modLatched ? 32'd4 : 32'd10) * elemCycles - 32'd1))
		else $error("Header length wrong.");
	a_cell_len: assert property (@(posedge clk) disable iff (reset)
		(clockEnable && segEnd && state == DATA)
		|-> (segCycles == (modLatched ? 32'd2 : 32'd3) * elemCycles - 32'd1))
		else $error("Bit cell length wrong.");
	a_start_stop: assert property (@(posedge clk) disable iff (reset)
		(clockEnable && segEnd && (state == START_BIT || state == STOP_BIT))
		|-> (segCycles == 32'd2 * elemCycles - 32'd1) ##1 (state == DATA || state == GUARD))
		else $error("Start or stop bit wrong.");
	a_guard_len: assert property (@(posedge clk) disable iff (reset)
		(clockEnable && segEnd && state == GUARD)
		|-> (segCycles + 32'd1 == elemCycles * (modLatched ? (rateLatched == 2'h0 ? 32'd9 : 32'd17)
			: (rateLatched == 2'h0 ? 32'd17 : (rateLatched == 2'h3 ? 32'd65 : 32'd33)))))
		else $error("Guard time wrong.");
	a_portion_bits: assert property (@(posedge clk) disable iff (reset)
		(clockEnable && segEnd && state == DATA && bitIndex == 7'd66)
		|=> (state == (modLatched ? STOP_BIT : GUARD)) && (bitIndex == 7'd67))
		else $error("Code word does not carry 67 bits.");
	a_fixed_order: assert property (@(posedge clk) disable iff (reset)
		(clockEnable && state == IDLE && control[CTRL_ENABLE_BIT])
		|=> (dataWord[63:60] == {$past(fixedStatus[2:0]), $past(fixedStatus[3])})
			&& (dataWord[66:64] == $past(fixedStatus[6:4])))
		else $error("Fixed portion order wrong.");
	a_tick_bound: assert property (@(posedge clk) disable iff (reset)
		(state != IDLE) |-> (tickCount < elemCycles))
		else $error("Element counter overran.");
	a_pwm_shape: assert property (@(posedge clk) disable iff (reset)
		(state == DATA && !modLatched)
		|-> (elemCount == 7'd0 ? lineLevel
			: (elemCount == 7'd2 ? !lineLevel : (lineLevel == !dataWord[0]))))
		else $error("PWM cell shape wrong.");
	a_man_midbit: assert property (@(posedge clk) disable iff (reset)
		(clockEnable && state == DATA && modLatched && elemCount == 7'd0 && elemEnd)
		|=> (lineLevel != $past(lineLevel)) && (lineLevel == dataWord[0]))
		else $error("Manchester mid-bit transition missing.");

endmodule

/* code_word_modulator_timing_bench.sv */
// Self-checking testbench for the code word modulator.
module code_word_modulator_timing_bench;
	import code_word_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	// A short base element keeps sixteen full code words well inside the run limit.
	localparam int BASE = 2;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic clockEnable = 1'b1;
	logic [7:0] address = 8'h00;
	logic [31:0] writeData = 32'h00000000;
	logic writeStrobe = 1'b0;
	logic readStrobe = 1'b0;
	logic [31:0] readData;
	logic dataOut;
	logic busy;
	logic wordDone;
	logic arm = 1'b0;
	logic [15:0] depth = 16'h0000;
	int failCount = 0;
	int cmpCount = 0;
	int doneCount = 0;
	bit expQ[$];
	logic [31:0] rv;

	code_word_modulator #(.ELEMENT_BASE_CYCLES(BASE)) code_word_modulator_i (.clk(clk),
		.reset(reset), .clockEnable(clockEnable), .address(address), .writeData(writeData),
		.writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData),
		.dataOut(dataOut), .busy(busy), .wordDone(wordDone));
	code_word_receiver code_word_receiver_i (.clk(clk), .reset(reset), .dataIn(dataOut),
		.arm(arm), .depth(depth));

	always #5 clk = ~clk;
	always @(posedge clk)
		if (wordDone === 1'b1)
			doneCount++;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] expected, input string msg);
		cmpCount++;
		if (seen !== expected)
		begin
			failCount++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, expected);
		end
	endtask

	task automatic testDone();
		$display("comparisons %0d mismatches %0d", cmpCount, failCount);
		if (failCount == 0 && cmpCount > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writeData <= d;
		writeStrobe <= 1'b1;
		@(posedge clk);
		writeStrobe <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		address <= a;
		readStrobe <= 1'b1;
		@(posedge clk);
		readStrobe <= 1'b0;
		@(negedge clk);
		d = readData;
	endtask

	task automatic push_el(input bit lvl, input int n);
		for (int i = 0; i < n; i++)
			expQ.push_back(lvl);
	endtask

	// Expected line per clock: one word, the idle cycle and the next word's first cycle.
	task automatic build_word(input bit man, input int rate, input logic [66:0] b, input int e);
		int guard;
		guard = man ? (rate == 0 ? 9 : 17) : (rate == 0 ? 17 : (rate == 3 ? 65 : 33));
		expQ.delete();
		for (int i = 0; i < 31; i++)
			push_el(~i[0], e);
		push_el(1'b0, man ? 4 * e : 10 * e);
		if (man)
		begin
			push_el(1'b0, e);
			push_el(1'b1, e);
		end
		for (int i = 0; i < 67; i++)
		begin
			if (man)
			begin
				push_el(~b[i], e);
				push_el(b[i], e);
			end
			else
			begin
				push_el(1'b1, e);
				push_el(~b[i], e);
				push_el(1'b0, e);
			end
		end
		if (man)
		begin
			push_el(1'b0, e);
			push_el(1'b1, e);
		end
		push_el(1'b0, guard * e + 1);
		push_el(1'b1, 1);
	endtask

	task automatic run_word(input bit man, input int rate);
		logic [31:0] hop;
		logic [31:0] ser;
		logic [31:0] fix;
		int e;
		int n;
		int good;
		hop = $urandom();
		ser = $urandom() & 32'h0fffffff;
		fix = $urandom() & 32'h0000007f;
		e = BASE * (man ? (rate == 0 ? 8 : 4) : (rate == 0 ? 4 : (rate == 3 ? 1 : 2)));
		build_word(man, rate, {fix[6:4], fix[2:0], fix[3], ser[27:0], hop}, e);
		wr(ADDR_HOPPING, hop);
		wr(ADDR_SERIAL, ser);
		wr(ADDR_FIXED, fix);
		depth <= 16'(expQ.size());
		arm <= 1'b1;
		doneCount = 0;
		wr(ADDR_CONTROL, {28'h0000000, rate[1:0], man, 1'b1});
		for (n = 0; n < 20000 && code_word_receiver_i.samples.size() < expQ.size(); n++)
			@(negedge clk);
		if (n == 20000)
		begin
			check(32'h0, 32'h1, "word capture timed out");
			testDone();
		end
		good = 0;
		while (good < expQ.size() && code_word_receiver_i.samples[good] === expQ[good])
			good++;
		check(32'(good), 32'(expQ.size()), "matching line cycles");
		check(32'(doneCount), 32'h1, "word end pulses");
		rd(ADDR_STATUS, rv);
		check({31'h00000000, rv[0]}, 32'h1, "status busy in word");
		wr(ADDR_CONTROL, 32'h0);
		arm <= 1'b0;
		for (n = 0; n < 20000 && busy !== 1'b0; n++)
			@(negedge clk);
		check(32'(busy), 32'h0, "busy after last word");
		if (busy !== 1'b0)
			testDone();
		$display("word test mode %0d rate %0d done", man, rate);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		void'($urandom(32'h286a21aa));
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd(ADDR_CONTROL, rv);
		check(rv, 32'h0, "control after reset");
		rd(ADDR_STATUS, rv);
		check(rv, 32'h0, "status after reset");
		wr(ADDR_SERIAL, 32'hffffffff);
		rd(ADDR_SERIAL, rv);
		check(rv, 32'h0fffffff, "serial width");
		wr(ADDR_FIXED, 32'hffffffff);
		rd(ADDR_FIXED, rv);
		check(rv, 32'h0000007f, "fixed width");
		wr(ADDR_CONTROL, 32'h0000001e);
		rd(ADDR_CONTROL, rv);
		check(rv, 32'h0000001e, "control readback");
		wr(ADDR_STATUS, 32'hffffffff);
		rd(ADDR_STATUS, rv);
		check(rv, 32'h0, "status is read only");
		rd(8'h14, rv);
		check(rv, 32'h0, "unmapped read");
		@(posedge clk);
		clockEnable <= 1'b0;
		wr(ADDR_CONTROL, 32'h1);
		clockEnable <= 1'b1;
		rd(ADDR_CONTROL, rv);
		check(rv, 32'h0000001e, "write while clock held");
		$display("register test done");
		for (int m = 0; m < 2; m++)
			for (int r = 0; r < 4; r++)
				run_word(m[0], r);
		rd(ADDR_STATUS, rv);
		check(rv, 32'h00100000, "words sent count");
		testDone();
	end
endmodule

/* code_word_pkg.sv */
// Constants and types shared by the code word modulator.
package code_word_pkg;

	// ----------------------------------------------------------------
	// Clock and element timing
	// ----------------------------------------------------------------
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int BASE_ELEMENT_NS = 100000;
	localparam int BASE_ELEMENT_CYCLES = BASE_ELEMENT_NS / CLOCK_PERIOD_NS;
	localparam logic [3:0] PWM_MULT_RATE00 = 4'h4;
	localparam logic [3:0] PWM_MULT_RATE01 = 4'h2;
	localparam logic [3:0] PWM_MULT_RATE10 = 4'h2;
	localparam logic [3:0] PWM_MULT_RATE11 = 4'h1;
	localparam logic [3:0] MAN_MULT_RATE00 = 4'h8;
	localparam logic [3:0] MAN_MULT_RATE01 = 4'h4;

	// ----------------------------------------------------------------
	// Segment lengths in basic pulse elements, and the last data bit index
	// ----------------------------------------------------------------
	localparam logic [6:0] PREAMBLE_ELEMS = 7'h1f;
	localparam logic [6:0] HEADER_PWM_ELEMS = 7'h0a;
	localparam logic [6:0] HEADER_MAN_ELEMS = 7'h04;
	localparam logic [6:0] START_BIT_ELEMS = 7'h02;
	localparam logic [6:0] STOP_BIT_ELEMS = 7'h02;
	localparam logic [6:0] CELL_PWM_ELEMS = 7'h03;
	localparam logic [6:0] CELL_MAN_ELEMS = 7'h02;
	localparam logic [6:0] GUARD_PWM_RATE00 = 7'h11;
	localparam logic [6:0] GUARD_PWM_RATE01 = 7'h21;
	localparam logic [6:0] GUARD_PWM_RATE10 = 7'h21;
	localparam logic [6:0] GUARD_PWM_RATE11 = 7'h41;
	localparam logic [6:0] GUARD_MAN_RATE00 = 7'h09;
	localparam logic [6:0] GUARD_MAN_RATE01 = 7'h11;
	localparam logic [6:0] LAST_BIT_INDEX = 7'h42;

	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CONTROL = 8'h00;
	localparam logic [7:0] ADDR_HOPPING = 8'h04;
	localparam logic [7:0] ADDR_SERIAL = 8'h08;
	localparam logic [7:0] ADDR_FIXED = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_MOD_BIT = 1;
	localparam int CTRL_RATE_LOW_BIT = 2;
	localparam int CTRL_RATE_HIGH_BIT = 3;
	localparam int CTRL_LONG_GUARD_BIT = 4;
	localparam int FIX_LOW_VOLTAGE_BIT = 4;
	localparam int FIX_CHECKSUM_LOW_BIT = 5;
	localparam int FIX_CHECKSUM_HIGH_BIT = 6;
	localparam logic [4:0] CONTROL_RESET = 5'h00;
	localparam logic [31:0] HOPPING_RESET = 32'h00000000;
	localparam logic [27:0] SERIAL_RESET = 28'h0000000;
	localparam logic [6:0] FIXED_RESET = 7'h00;

	typedef enum logic [6:0] {
		IDLE = 7'b0000001,
		PREAMBLE = 7'b0000010,
		HEADER = 7'b0000100,
		START_BIT = 7'b0001000,
		DATA = 7'b0010000,
		STOP_BIT = 7'b0100000,
		GUARD = 7'b1000000
	} phase_e;

endpackage

/* code_word_receiver.sv */
// Receiver model that records the modulated line, one sample per clock.
module code_word_receiver
(
	input wire logic clk,
	input wire logic reset,
	input wire logic dataIn,
	input wire logic arm,
	input wire logic [15:0] depth
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Capture
	// ----------------------------------------------------------------
	// Capture starts at the first high level, so the idle lead-in is not compared.
	bit recording;
	logic samples[$];

	always @(posedge clk)
	begin
		if (reset || !arm)
		begin
			recording = 1'b0;
			samples.delete();
		end
		else if (samples.size() < depth && (recording || dataIn === 1'b1))
		begin
			recording = 1'b1;
			samples.push_back(dataIn);
		end
	end
endmodule
